// *** rtl/pif_flags.sv ***
// peripheral interrupt request flag bank with avalon-mm registers
//
// Overview of operation
// - second enable register: only bit 0 exists
// - request register eight flags, reset zero
// - bit 7 sets while gate inactive, sticky
// - bit 6 sets on conversion done, sticky
// - bit 5 follows receive buffer full
// - bit 4 follows transmit buffer empty
// - bit 3 sets on sync port done
// - capture mode: capture event sets bit 2
// - compare mode: match event sets bit 2
// - bit 1 sets on period match
// - bit 0 sets on count overflow
// - flags latch regardless of any interrupt enable
// - peripheral enable gates every request into periph_irq_req; irq is not gated by it
// - enable bit per flag, same position
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module pif_flags (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        gate_active_pin,
    input  wire logic        adc_done_evt,
    input  wire logic        rx_buf_full,
    input  wire logic        tx_buf_empty,
    input  wire logic        sync_port_done_evt,
    input  wire logic [2:0]  capcmp_a_mode,
    input  wire logic        capcmp_a_capture_evt,
    input  wire logic        capcmp_a_match_evt,
    input  wire logic        period_match_evt,
    input  wire logic        count_overflow_evt,
    input  wire logic        capcmp_b_flag,
    output logic             periph_irq_req,
    output logic             irq
);
    // ------------------------------------------------------------
    // types and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  req;     // writable request flags
        logic [7:0]  en1;     // peripheral_enable_one
        logic        en2;     // capcmp_b_irq_enable
        logic        glb;     // global_irq_enable
        logic        pen;     // peripheral_irq_enable
        logic [7:0]  msk;     // status mask
        logic        rx_prv;  // receive level, last cycle
        logic        tx_prv;  // transmit level, last cycle
        logic        ack;     // bus answer phase
        logic [31:0] rdata;   // registered read data
    } pif_state_s;
    pif_state_s s_r;
    pif_state_s s_nxt;

    // ------------------------------------------------------------
    // address decode, used by read mux and write strobes
    // ------------------------------------------------------------
    function automatic logic pif_hit(input logic [4:0] a, input logic [4:0] ofs);
        pif_hit = (a == ofs);
    endfunction

    logic        gate_act;  // filtered gate level, one = active
    logic        gate_inact; // gate inactive condition
    logic [7:0]  set_v;     // flag set events this cycle
    logic [7:0]  flags;     // visible request register
    logic [7:0]  sts;       // sticky event status
    logic [7:0]  sts_set;   // events into status
    logic [7:0]  sts_clr;   // write-one-to-clear
    logic        wr_go;     // write takes effect now
    logic        cca_set;   // capcmp_a flag condition
    logic [7:0]  wbyte;     // low byte of write data

    // ------------------------------------------------------------
    // gate pin synchroniser
    // ------------------------------------------------------------
    // gate comes from a pin, so it is filtered before use
    pif_sync #(
        .RST_VAL (1'b0)
    ) u_gate_sync (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .pin_in    (gate_active_pin),
        .level_out (gate_act)
    );

    assign gate_inact = ~gate_act;
    // low byte carries data
    assign wbyte      = avs_writedata[7:0];
    // lands at answer edge
    assign wr_go      = avs_write & s_r.ack;

    // ------------------------------------------------------------
    // flag set conditions
    // ------------------------------------------------------------
    // pwm mode is decoded to no event, so it never reaches the flag
    always_comb begin
        cca_set = 1'b0;
        case (pif_pkg::pif_ccp_mode_e'(capcmp_a_mode))
            pif_pkg::PIF_MODE_CAPTURE: begin
                cca_set = capcmp_a_capture_evt;
            end

            pif_pkg::PIF_MODE_COMPARE: begin
                cca_set = capcmp_a_match_evt;
            end

            pif_pkg::PIF_MODE_PWM: begin
                cca_set = 1'b0;
            end

            default: begin
                // illegal codes set nothing
                cca_set = 1'b0;
            end
        endcase
    end

    // no enable term appears here: flags latch whatever the interrupt enables hold
    always_comb begin
        set_v                      = 8'h00;
        set_v[pif_pkg::PIF_B_GATE] = gate_inact;
        set_v[pif_pkg::PIF_B_ADC]  = adc_done_evt;
        set_v[pif_pkg::PIF_B_SSP]  = sync_port_done_evt;
        set_v[pif_pkg::PIF_B_CCA]  = cca_set;
        set_v[pif_pkg::PIF_B_PER]  = period_match_evt;
        set_v[pif_pkg::PIF_B_OVF]  = count_overflow_evt;
    end

    // rx and tx are live levels; their owners clear them on data access
    always_comb begin
        flags                    = s_r.req & pif_pkg::PIF_REQ1_WMSK;
        flags[pif_pkg::PIF_B_RX] = rx_buf_full;
        flags[pif_pkg::PIF_B_TX] = tx_buf_empty;
    end

    // ------------------------------------------------------------
    // sticky event status for the local interrupt
    // ------------------------------------------------------------
    // rx/tx report rising edges
    always_comb begin
        sts_set                    = set_v;
        sts_set[pif_pkg::PIF_B_RX] = rx_buf_full & ~s_r.rx_prv;
        sts_set[pif_pkg::PIF_B_TX] = tx_buf_empty & ~s_r.tx_prv;
        sts_clr = (wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_STS)) ? wbyte : 8'h00;
    end

    pif_w1c #(
        .W (8)
    ) u_sts (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .set_in  (sts_set),
        .clr_in  (sts_clr),
        .q_out   (sts)
    );

    // ------------------------------------------------------------
    // next state: bus handshake, register writes, flag latching
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            // edge detect history
            s_nxt.rx_prv = rx_buf_full;
            s_nxt.tx_prv = tx_buf_empty;
            // one wait cycle, then the answer phase
            s_nxt.ack = (avs_read | avs_write) & ~s_r.ack;
            // read data captured entering the answer phase
            if (avs_read && !s_r.ack) begin
                s_nxt.rdata = 32'h0000_0000;
                if (pif_hit(avs_address, pif_pkg::PIF_OFS_REQ1)) begin
                    s_nxt.rdata[7:0] = flags;
                end else if (pif_hit(avs_address, pif_pkg::PIF_OFS_EN1)) begin
                    s_nxt.rdata[7:0] = s_r.en1;
                end else if (pif_hit(avs_address, pif_pkg::PIF_OFS_EN2)) begin
                    // upper bits unimplemented, read zero
                    s_nxt.rdata[pif_pkg::PIF_B_CCB] = s_r.en2;
                end else if (pif_hit(avs_address, pif_pkg::PIF_OFS_CTL)) begin
                    s_nxt.rdata[pif_pkg::PIF_B_GLB] = s_r.glb;
                    s_nxt.rdata[pif_pkg::PIF_B_PEN] = s_r.pen;
                end else if (pif_hit(avs_address, pif_pkg::PIF_OFS_STS)) begin
                    s_nxt.rdata[7:0] = sts;
                end else if (pif_hit(avs_address, pif_pkg::PIF_OFS_MSK)) begin
                    s_nxt.rdata[7:0] = s_r.msk;
                end
                // unmapped: answers zero
            end

            // request flags: a write stores, but a set event wins
            if (wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_REQ1)) begin
                s_nxt.req = (wbyte | set_v) & pif_pkg::PIF_REQ1_WMSK;
            end else begin
                s_nxt.req = (s_r.req | set_v) & pif_pkg::PIF_REQ1_WMSK;
            end

            // enable and control registers
            if (wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_EN1)) begin
                s_nxt.en1 = wbyte;
            end

            if (wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_EN2)) begin
                s_nxt.en2 = wbyte[pif_pkg::PIF_B_CCB];
            end

            if (wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_CTL)) begin
                s_nxt.glb = wbyte[pif_pkg::PIF_B_GLB];
                s_nxt.pen = wbyte[pif_pkg::PIF_B_PEN];
            end

            if (wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_MSK)) begin
                s_nxt.msk = wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // async reset of all state, tx_prv loads one
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r.req    <= pif_pkg::PIF_REQ1_RST;
            s_r.en1    <= pif_pkg::PIF_EN1_RST;
            s_r.en2    <= pif_pkg::PIF_EN2_RST;
            s_r.glb    <= pif_pkg::PIF_CTL_RST[1];
            s_r.pen    <= pif_pkg::PIF_CTL_RST[0];
            s_r.msk    <= pif_pkg::PIF_MSK_RST;
            s_r.rx_prv <= 1'b0;
            s_r.tx_prv <= 1'b1; // idle: buffer empty
            s_r.ack    <= 1'b0;
            s_r.rdata  <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // software should clear stale flags before enabling
    // this logic simply forwards whatever is pending
    assign periph_irq_req = s_r.glb & s_r.pen &
        ((|(flags & s_r.en1)) | (capcmp_b_flag & s_r.en2));
    // any unmasked sticky bit
    assign irq             = |(sts & s_r.msk);
    // one wait per access
    assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
    // from its register
    assign avs_readdata    = s_r.rdata;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking pif_cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    logic wr_req1; // helper: request register written now
    assign wr_req1 = wr_go && pif_hit(avs_address, pif_pkg::PIF_OFS_REQ1);

    // register map
    chk_en2_upper_zero: assert property (
        avs_read && s_r.ack && pif_hit(avs_address, pif_pkg::PIF_OFS_EN2)
        |-> avs_readdata[31:1] == 31'h0000_0000)
        else $error("upper bits of enable two not zero");

    // flags latch on events
    chk_gate_sets: assert property (
        clk_en && !gate_act |=> flags[pif_pkg::PIF_B_GATE])
        else $error("gate flag not set while gate inactive");

    chk_adc_sticky: assert property (
        flags[pif_pkg::PIF_B_ADC] && !wr_req1 |=> flags[pif_pkg::PIF_B_ADC])
        else $error("converter flag dropped without write");

    chk_rx_readonly: assert property (
        avs_read && !avs_waitrequest && $past(avs_waitrequest)
        && pif_hit(avs_address, pif_pkg::PIF_OFS_REQ1)
        |-> avs_readdata[pif_pkg::PIF_B_RX] == $past(rx_buf_full))
        else $error("receive flag not live in read data");

    chk_ssp_sets: assert property (
        clk_en && sync_port_done_evt |=> flags[pif_pkg::PIF_B_SSP])
        else $error("sync port flag not set");

    // capcmp_a by mode
    chk_capture_set: assert property (
        clk_en && capcmp_a_mode == pif_pkg::PIF_MODE_CAPTURE && capcmp_a_capture_evt
        |=> flags[pif_pkg::PIF_B_CCA])
        else $error("capture did not set flag");

    chk_compare_set: assert property (
        clk_en && capcmp_a_mode == pif_pkg::PIF_MODE_COMPARE && capcmp_a_match_evt
        |=> flags[pif_pkg::PIF_B_CCA])
        else $error("compare match did not set flag");

    chk_pwm_quiet: assert property (
        capcmp_a_mode == pif_pkg::PIF_MODE_PWM && !flags[pif_pkg::PIF_B_CCA] && !wr_req1
        |=> !flags[pif_pkg::PIF_B_CCA])
        else $error("pwm mode set capture flag");

    chk_period_set: assert property (
        clk_en && period_match_evt |=> flags[pif_pkg::PIF_B_PER])
        else $error("period match flag not set");

    chk_ovf_no_enable: assert property (
        clk_en && s_r.en1 == 8'h00 && !s_r.glb && count_overflow_evt
        |=> flags[pif_pkg::PIF_B_OVF])
        else $error("overflow flag not latched while disabled");

    // core request gating
    chk_irq_gated: assert property (
        !(s_r.glb && s_r.pen) |-> !periph_irq_req)
        else $error("request reached core while disabled");

    chk_req_or: assert property (
        s_r.glb && s_r.pen && |(flags & s_r.en1) |-> periph_irq_req)
        else $error("enabled flag did not raise request");

    // bus timing
    chk_one_wait: assert property (
        clk_en && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer later than one wait cycle");

    // main scenarios
    cov_read_req: cover property (avs_read && !avs_waitrequest
        && pif_hit(avs_address, pif_pkg::PIF_OFS_REQ1));

    cov_core_req: cover property ($rose(periph_irq_req));

    cov_irq_out: cover property ($rose(irq));

    cov_set_vs_clear: cover property (wr_req1 && |set_v);
endmodule

// *** rtl/pif_pkg.sv ***
// shared constants and types of the peripheral interrupt flag bank
package pif_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned PIF_AW = 5;   // byte address width
    localparam int unsigned PIF_DW = 32;  // bus data width
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] PIF_OFS_REQ1 = 5'h00; // peripheral_request_one
    localparam logic [4:0] PIF_OFS_EN1  = 5'h04; // peripheral_enable_one
    localparam logic [4:0] PIF_OFS_EN2  = 5'h08; // peripheral_enable_two
    localparam logic [4:0] PIF_OFS_CTL  = 5'h0c; // irq_control_reg
    localparam logic [4:0] PIF_OFS_STS  = 5'h10; // sticky event status
    localparam logic [4:0] PIF_OFS_MSK  = 5'h14; // status mask
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned PIF_B_GATE = 7; // gate_event_flag
    localparam int unsigned PIF_B_ADC  = 6; // converter_done_flag
    localparam int unsigned PIF_B_RX   = 5; // serial_rx_flag
    localparam int unsigned PIF_B_TX   = 4; // serial_tx_flag
    localparam int unsigned PIF_B_SSP  = 3; // sync_port_done_flag
    localparam int unsigned PIF_B_CCA  = 2; // capcmp_a_flag
    localparam int unsigned PIF_B_PER  = 1; // period_match_flag
    localparam int unsigned PIF_B_OVF  = 0; // count_overflow_flag
    localparam int unsigned PIF_B_GLB  = 7; // global_irq_enable
    localparam int unsigned PIF_B_PEN  = 6; // peripheral_irq_enable
    localparam int unsigned PIF_B_CCB  = 0; // capcmp_b_irq_enable
    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] PIF_REQ1_RST  = 8'h00;
    localparam logic [7:0] PIF_EN1_RST   = 8'h00;
    localparam logic       PIF_EN2_RST   = 1'b0;
    localparam logic [1:0] PIF_CTL_RST   = 2'b00;
    localparam logic [7:0] PIF_MSK_RST   = 8'h00;
    localparam logic [7:0] PIF_REQ1_WMSK = 8'hcf; // rx and tx bits read only
    // ------------------------------------------------------------
    // capture/compare unit mode, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PIF_MODE_CAPTURE = 3'b001,
        PIF_MODE_COMPARE = 3'b010,
        PIF_MODE_PWM     = 3'b100
    } pif_ccp_mode_e;
endpackage

// *** rtl/pif_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pif_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic pin_in,
    output logic      level_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ff;     // ff[0] is the metastable stage
        logic       stable; // filtered level
    } pif_sync_s;
    pif_sync_s s_r;
    pif_sync_s s_nxt;

    // shift and accept only when stages two and three agree
    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            s_nxt.ff = {s_r.ff[1:0], pin_in};
            if (s_r.ff[1] == s_r.ff[2]) begin
                s_nxt.stable = s_r.ff[2];
            end
        end
    end

    // register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '{ff: {3{RST_VAL}}, stable: RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_out = s_r.stable;
endmodule

// *** rtl/pif_w1c.sv ***
// sticky status bank, set by events, cleared by writing ones
`timescale 1ns/1ps
module pif_w1c #(
    parameter int unsigned W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    output logic      [W-1:0] q_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] q; // sticky bits
    } pif_w1c_s;
    pif_w1c_s s_r;
    pif_w1c_s s_nxt;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        s_nxt = s_r;
        if (clk_en) begin
            s_nxt.q = (s_r.q & ~clr_in) | set_in;
        end
    end

    // register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.q;
endmodule

// *** verification/pif_periph_model.sv ***
// behavioural model of the peripherals that feed the flag bank
`timescale 1ns/1ps
module pif_periph_model (
    input  wire logic clk_sys,
    output logic      gate_active_pin,
    output logic      adc_done_evt,
    output logic      rx_buf_full,
    output logic      tx_buf_empty,
    output logic      sync_port_done_evt,
    output logic      capcmp_a_capture_evt,
    output logic      capcmp_a_match_evt,
    output logic      period_match_evt,
    output logic      count_overflow_evt,
    output logic      capcmp_b_flag
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0] evt_r; // one-cycle event strobes
    logic [3:0] lvl_r; // gate, rx, tx, second unit flag
    // gate starts active, but the synchroniser resets inactive, so bit 7 sets once after reset
    initial begin
        evt_r = 6'h00;
        lvl_r = 4'h1;
    end
    assign {adc_done_evt, sync_port_done_evt, capcmp_a_capture_evt} = evt_r[5:3];
    assign {capcmp_a_match_evt, period_match_evt, count_overflow_evt} = evt_r[2:0];
    assign {capcmp_b_flag, tx_buf_empty, rx_buf_full, gate_active_pin} = lvl_r;
    // ------------------------------------------------------------
    // commands, always launched just after a rising edge
    // ------------------------------------------------------------
    // single-cycle strobe, index 0 is the conversion event
    task automatic pulse(input int idx);
        @(posedge clk_sys);
        evt_r[5-idx] <= 1'b1;
        @(posedge clk_sys);
        evt_r <= 6'h00;
    endtask
    // level change of a buffer state, gate pin or second unit flag
    task automatic level(input int idx, input logic v);
        @(posedge clk_sys);
        lvl_r[idx] <= v;
    endtask
endmodule

// *** verification/tb_top.sv ***
// self-checking bench of the peripheral interrupt flag bank
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, reset_n, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed;
    logic [2:0]  capcmp_a_mode;
    logic        gate, adc, rx, tx, sync_serial_port, cap, mat, per, ovf, ccb, periph_irq_req, irq;
    logic [7:0]  ref_req, ref_sts, ref_en1, ref_en2, ref_ctl, ref_msk; // reference registers
    logic [3:0]  ref_lv;       // commanded levels
    int          errors, comparisons, cycles;
    pif_flags pif_flags_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .gate_active_pin(gate), .adc_done_evt(adc),
        .rx_buf_full(rx), .tx_buf_empty(tx), .sync_port_done_evt(sync_serial_port),
        .capcmp_a_mode(capcmp_a_mode), .capcmp_a_capture_evt(cap), .capcmp_a_match_evt(mat),
        .period_match_evt(per), .count_overflow_evt(ovf), .capcmp_b_flag(ccb),
        .periph_irq_req(periph_irq_req), .irq(irq));
    pif_periph_model pif_periph_model_i (.clk_sys(clk_sys), .gate_active_pin(gate),
        .adc_done_evt(adc), .rx_buf_full(rx), .tx_buf_empty(tx), .sync_port_done_evt(sync_serial_port),
        .capcmp_a_capture_evt(cap), .capcmp_a_match_evt(mat), .period_match_evt(per),
        .count_overflow_evt(ovf), .capcmp_b_flag(ccb));
    // ------------------------------------------------------------
    // clock, 100 ns period, and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected read value, rx and tx bits follow the live levels
    function automatic logic [7:0] expv(input logic [4:0] a);
        case (a)
            pif_pkg::PIF_OFS_REQ1: return {ref_req[7:6], ref_lv[1], ref_lv[2], ref_req[3:0]};
            pif_pkg::PIF_OFS_EN1:  return ref_en1;
            pif_pkg::PIF_OFS_EN2:  return ref_en2;
            pif_pkg::PIF_OFS_CTL:  return ref_ctl;
            pif_pkg::PIF_OFS_STS:  return ref_sts;
            pif_pkg::PIF_OFS_MSK:  return ref_msk;
            default:               return 8'h00; // unmapped reads zero
        endcase
    endfunction
    task automatic cmp_val(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // master side, request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {seed[31:8], d}; // upper bits are ignored
        avs_read      <= ~w;
        avs_write     <= w;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
        case (a)
            pif_pkg::PIF_OFS_REQ1: ref_req = (ref_req & 8'h30) | (d & pif_pkg::PIF_REQ1_WMSK);
            pif_pkg::PIF_OFS_EN1:  ref_en1 = d;
            pif_pkg::PIF_OFS_EN2:  ref_en2 = d & 8'h01;
            pif_pkg::PIF_OFS_CTL:  ref_ctl = d & 8'hc0;
            pif_pkg::PIF_OFS_STS:  ref_sts = ref_sts & ~d;
            pif_pkg::PIF_OFS_MSK:  ref_msk = d;
            default:               ref_req = ref_req; // unmapped write ignored
        endcase
    endtask
    task automatic rd_chk(input logic [4:0] a);
        logic [31:0] q;
        bus(a, 1'b0, 8'h00, q);
        cmp_val("readdata", q, {24'h000000, expv(a)});
    endtask
    // gated request and masked status outputs, looked at mid-cycle
    task automatic out_chk();
        logic [7:0] v;
        @(negedge clk_sys);
        v = expv(pif_pkg::PIF_OFS_REQ1);
        cmp_val("periph_irq_req", {31'h0, periph_irq_req},
                {31'h0, ref_ctl[7] & ref_ctl[6] & (|(v & ref_en1) | (ref_lv[3] & ref_en2[0]))});
        cmp_val("irq", {31'h0, irq}, {31'h0, |(ref_sts & ref_msk)});
    endtask
    // event pulse: flag latches whatever the enables say, capcmp only in its mode
    task automatic ev(input int i);
        logic [7:0] b;
        pif_periph_model_i.pulse(i);
        b = (i == 0) ? 8'h40 : (i == 1) ? 8'h08 : (i == 4) ? 8'h02 : (i == 5) ? 8'h01 : 8'h04;
        if ((i == 2 && capcmp_a_mode != 3'b001) || (i == 3 && capcmp_a_mode != 3'b010))
            b = 8'h00;
        ref_req = ref_req | b;
        ref_sts = ref_sts | b;
    endtask
    task automatic lvl(input int i, input logic v);
        pif_periph_model_i.level(i, v);
        @(posedge clk_sys); // status edge detect settles
        if (v && !ref_lv[i] && (i == 1 || i == 2))
            ref_sts = ref_sts | ((i == 1) ? 8'h20 : 8'h10);
        ref_lv[i] = v;
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {clk_en, capcmp_a_mode, seed, errors, comparisons, cycles} = {1'b1, 3'b001, 32'd81876, 96'h0};
        {ref_req, ref_sts, ref_en1, ref_en2, ref_ctl, ref_msk, ref_lv} = {8'h80, 8'h80, 32'h0, 4'h1};
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int a = 0; a < 28; a += 4) rd_chk(a[4:0]);
        wr(pif_pkg::PIF_OFS_REQ1, 8'h00);
        wr(pif_pkg::PIF_OFS_STS, 8'hff);
        wr(pif_pkg::PIF_OFS_EN2, 8'hff);
        wr(5'h18, 8'hff);
        wr(pif_pkg::PIF_OFS_REQ1, 8'hff);
        for (int a = 0; a < 28; a += 4) rd_chk(a[4:0]);
        wr(pif_pkg::PIF_OFS_REQ1, 8'h00);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_sys) capcmp_a_mode <= 3'(1 << m);
            for (int i = 0; i < 6; i++) begin
                ev(i);
                rd_chk(pif_pkg::PIF_OFS_REQ1);
            end
            wr(pif_pkg::PIF_OFS_REQ1, 8'h00);
        end
        for (int i = 1; i < 3; i++) begin
            lvl(i, 1'b1);
            rd_chk(pif_pkg::PIF_OFS_REQ1);
            lvl(i, 1'b0);
            rd_chk(pif_pkg::PIF_OFS_REQ1);
        end
        lvl(0, 1'b0);
        repeat (6) @(posedge clk_sys);
        ref_req[7] = 1'b1;
        ref_sts[7] = 1'b1;
        rd_chk(pif_pkg::PIF_OFS_REQ1);
        lvl(0, 1'b1);
        repeat (6) @(posedge clk_sys);
        wr(pif_pkg::PIF_OFS_REQ1, 8'h00);
        wr(pif_pkg::PIF_OFS_STS, 8'hff);
        rd_chk(pif_pkg::PIF_OFS_REQ1);
        @(posedge clk_sys) clk_en <= 1'b0;
        pif_periph_model_i.pulse(0); // frozen, must be missed
        @(posedge clk_sys) clk_en <= 1'b1;
        rd_chk(pif_pkg::PIF_OFS_REQ1);
        for (int k = 0; k < 120; k++) begin
            wr(3'(rnd() % 6) << 2, rnd());
            if (seed[9]) ev(rnd() % 6);
            if (seed[10]) lvl(1 + rnd() % 3, seed[4]);
            if (seed[11]) @(posedge clk_sys) capcmp_a_mode <= 3'(1 << (rnd() % 3));
            out_chk();
            rd_chk(3'(rnd() % 7) << 2);
        end
        close_out();
    end
endmodule
